// ---- design/drt_regs.svh ----
// register indices, field positions, reset values and timing counts of the timer block
`ifndef DRT_REGS_SVH
`define DRT_REGS_SVH

// word index of each register; byte address is four times the index
`define DRT_IDX_FIRST_PRE  10'h0aa
`define DRT_IDX_SECOND_PRE 10'h0ab
`define DRT_IDX_FIRST_LOW  10'h0ac
`define DRT_IDX_SECOND_LOW 10'h0ad
`define DRT_IDX_CTRL       10'h0c0
`define DRT_IDX_FLAGS      10'h0c1
`define DRT_IDX_MASK       10'h0c2
`define DRT_IDX_DIR        10'h0c3
`define DRT_IDX_DOUT       10'h0c4
`define DRT_IDX_PINS       10'h0c5

// control register fields
`define DRT_CTRL_FIRST_MODE  0
`define DRT_CTRL_FIRST_RUN   1
`define DRT_CTRL_SECOND_MODE 2
`define DRT_CTRL_SECOND_RUN  3
`define DRT_CTRL_WR_MASK     8'h0f

// flag, mask, direction and data bit of each timer
`define DRT_BIT_FIRST  0
`define DRT_BIT_SECOND 1

// reset values
`define DRT_RST_BYTE 8'h00
`define DRT_RST_PAIR 2'b00

// timing counts in system clocks / ticks
`define DRT_TICK_LAST 8'd254
`define DRT_PWM_LAST  8'd254

`define DRT_HSIZE_WORD 3'b010

`endif

// ---- design/drt_pkg.sv ----
// types shared by the dual reload timer block
package drt_pkg;

  typedef enum logic [2:0] {
    CH_STOP  = 3'b001,
    CH_TIMER = 3'b010,
    CH_PWM   = 3'b100
  } drt_chan_state_t;

  typedef struct packed {
    drt_chan_state_t state;
    logic [15:0]     cnt;
    logic [7:0]      div;
    logic            irq;
    logic            pwm;
  } drt_chan_st_t;

  typedef struct packed {
    logic        ph_wr;
    logic        ph_rd;
    logic        rd_done;
    logic [9:0]  idx;
    logic [31:0] hrdata;
  } drt_ahb_st_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] first_pre;
    logic [7:0] second_pre;
    logic [7:0] first_low;
    logic [7:0] second_low;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [1:0] dir;
    logic [1:0] dout;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
    logic       irq;
  } drt_top_st_t;

endpackage

// ---- design/drt_chan.sv ----
// one reload timer channel with timer and pwm modes
`timescale 1ns/1ps
module drt_chan
  import drt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       mode,
  input  wire logic [7:0] pre,
  input  wire logic [7:0] low,
  output logic            irq_pulse,
  output logic            pwm_out
);
`include "drt_regs.svh"

  drt_chan_st_t st_r;
  drt_chan_st_t st_nxt;
  logic [15:0]  reload;

  // ==========================================================
  // next state
  always_comb begin
    reload     = {pre, low};
    st_nxt     = st_r;
    st_nxt.irq = 1'b0;
    case (st_r.state)
      CH_STOP: begin
        st_nxt.cnt = reload;  // RULE6 RULE3
        st_nxt.div = 8'h00;
        if (run) begin
          st_nxt.state = mode ? CH_PWM : CH_TIMER;  // RULE2
          if (mode) begin
            st_nxt.cnt = 16'h0000;
          end
        end
      end
      CH_TIMER: begin
        if (!run) begin
          st_nxt.state = CH_STOP;
          st_nxt.cnt   = reload;  // RULE6
          st_nxt.div   = 8'h00;
        end else if (mode) begin
          st_nxt.state = CH_PWM;
          st_nxt.cnt   = 16'h0000;
          st_nxt.div   = 8'h00;
        end else if (st_r.div == `DRT_TICK_LAST) begin  // RULE10
          st_nxt.div = 8'h00;
          if (st_r.cnt == 16'h0000) begin
            st_nxt.cnt = reload;  // RULE8 RULE5
            st_nxt.irq = 1'b1;  // RULE8 RULE11
          end else begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
          end
        end else begin
          st_nxt.div = st_r.div + 8'h01;
        end
      end
      CH_PWM: begin
        if (!run) begin
          st_nxt.state = CH_STOP;
          st_nxt.cnt   = reload;
          st_nxt.div   = 8'h00;
        end else if (!mode) begin
          st_nxt.state = CH_TIMER;
          st_nxt.cnt   = reload;
          st_nxt.div   = 8'h00;
        end else if (st_r.div == pre) begin  // RULE14 RULE12
          st_nxt.div = 8'h00;
          st_nxt.cnt = (st_r.cnt[7:0] == `DRT_PWM_LAST) ? 16'h0000
                       : {8'h00, st_r.cnt[7:0] + 8'h01};  // RULE17
        end else begin
          st_nxt.div = st_r.div + 8'h01;
        end
      end
      default: begin
        st_nxt.state = CH_STOP;
      end
    endcase
    // no flag source exists in pwm state
    st_nxt.pwm = (st_nxt.state == CH_PWM) && (st_nxt.cnt[7:0] < low);  // RULE17 RULE13 RULE15
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '{state: CH_STOP, cnt: 16'h0000, div: 8'h00, irq: 1'b0, pwm: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irq_pulse = st_r.irq;
  assign pwm_out   = st_r.pwm;

endmodule

// ---- design/drt_ahb.sv ----
// ahb-lite slave front end: word writes with no wait, reads with one wait state
`timescale 1ns/1ps
module drt_ahb
  import drt_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   wr_en,
  output logic [9:0]             wr_idx,
  output logic [31:0]            wr_data,
  output logic [9:0]             rd_idx,
  input  wire logic [31:0]       rd_data
);
`include "drt_regs.svh"

  drt_ahb_st_t st_r;
  drt_ahb_st_t st_nxt;

  // ==========================================================
  // phase tracking
  // the read wait state lets a write in the previous data phase land first
  always_comb begin
    st_nxt = st_r;
    if (st_r.ph_rd && !st_r.rd_done) begin
      st_nxt.hrdata  = rd_data;
      st_nxt.rd_done = 1'b1;
    end else begin
      st_nxt.ph_wr   = 1'b0;
      st_nxt.ph_rd   = 1'b0;
      st_nxt.rd_done = 1'b0;
      if (hsel && htrans[1]) begin
        st_nxt.idx   = 10'(haddr[ADDR_W-1:2]);
        st_nxt.ph_wr = hwrite && (hsize == `DRT_HSIZE_WORD);
        st_nxt.ph_rd = !hwrite;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '{ph_wr: 1'b0, ph_rd: 1'b0, rd_done: 1'b0, idx: 10'h000,
                hrdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = !(st_r.ph_rd && !st_r.rd_done);
  assign hresp     = 1'b0;
  assign hrdata    = st_r.hrdata;
  assign wr_en     = st_r.ph_wr;
  assign wr_idx    = st_r.idx;
  assign wr_data   = hwdata;
  assign rd_idx    = st_r.idx;

endmodule

// ---- design/drt_top.sv ----
// dual reload timer / pwm block with ahb-lite register access
//
// Summary of operation
// [RULE1] control: run and mode bits per timer
// [RULE2] mode zero timer, one pwm, per timer
// [RULE3] run low holds timer stopped, counter preset
// [RULE4] pwm mode forces pin to output
// [RULE5] timer mode reload is prescale:low byte
// [RULE6] clearing run reloads the counter
// [RULE7] counter value never readable by software
// [RULE8] underflow reloads and sets interrupt flag
// [RULE9] flag cleared only by software write
// [RULE10] one count per 255 clocks
// [RULE11] first interrupt one interval after run
// [RULE12] prescale is reload high byte, pwm prescaler
// [RULE13] low byte is reload low, pwm duty
// [RULE14] pwm period 255 times prescale plus one
// [RULE15] pwm mode raises no interrupt flag
// [RULE16] pin override ignores run bit
// [RULE17] pwm pin high while phase below duty
`timescale 1ns/1ps
module drt_top
  import drt_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              CLK_SYS,
  input  wire logic              RST_B,
  input  wire logic              HSEL,
  input  wire logic [ADDR_W-1:0] HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  output logic [31:0]            HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  output logic                   IRQ,
  output logic [1:0]             PWM_PIN_O,
  output logic [1:0]             PWM_PIN_OE,
  input  wire logic [1:0]        PWM_PIN_I
);
`include "drt_regs.svh"

  // ==========================================================
  // signals
  drt_top_st_t st_r;
  drt_top_st_t st_nxt;
  logic        wr_en;
  logic [9:0]  wr_idx;
  logic [31:0] wr_data;
  logic [9:0]  rd_idx;
  logic [31:0] rd_data;
  logic [7:0]  wb;
  logic [1:0]  irq_ev;
  logic [1:0]  pwm_lvl;
  logic [1:0]  mode_v;
  logic [1:0]  run_v;

  // ==========================================================
  // bus front end
  drt_ahb #(
    .ADDR_W (ADDR_W)
  ) u_ahb (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hsize     (HSIZE),
    .hwdata    (HWDATA),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (wr_data),
    .rd_idx    (rd_idx),
    .rd_data   (rd_data)
  );

  // ==========================================================
  // control fields
  assign mode_v[`DRT_BIT_FIRST]  = st_r.ctrl[`DRT_CTRL_FIRST_MODE];  // RULE1
  assign mode_v[`DRT_BIT_SECOND] = st_r.ctrl[`DRT_CTRL_SECOND_MODE];  // RULE1
  assign run_v[`DRT_BIT_FIRST]   = st_r.ctrl[`DRT_CTRL_FIRST_RUN];  // RULE1
  assign run_v[`DRT_BIT_SECOND]  = st_r.ctrl[`DRT_CTRL_SECOND_RUN];  // RULE1

  // ==========================================================
  // timer channels
  drt_chan u_first (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .run       (run_v[`DRT_BIT_FIRST]),
    .mode      (mode_v[`DRT_BIT_FIRST]),
    .pre       (st_r.first_pre),
    .low       (st_r.first_low),
    .irq_pulse (irq_ev[`DRT_BIT_FIRST]),
    .pwm_out   (pwm_lvl[`DRT_BIT_FIRST])
  );

  drt_chan u_second (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .run       (run_v[`DRT_BIT_SECOND]),
    .mode      (mode_v[`DRT_BIT_SECOND]),
    .pre       (st_r.second_pre),
    .low       (st_r.second_low),
    .irq_pulse (irq_ev[`DRT_BIT_SECOND]),
    .pwm_out   (pwm_lvl[`DRT_BIT_SECOND])
  );

  // ==========================================================
  // read mux
  // there is deliberately no index that returns a channel count
  always_comb begin
    rd_data = 32'h0000_0000;  // RULE7
    if (rd_idx == `DRT_IDX_FIRST_PRE) begin
      rd_data = {24'h00_0000, st_r.first_pre};
    end else if (rd_idx == `DRT_IDX_SECOND_PRE) begin
      rd_data = {24'h00_0000, st_r.second_pre};
    end else if (rd_idx == `DRT_IDX_FIRST_LOW) begin
      rd_data = {24'h00_0000, st_r.first_low};
    end else if (rd_idx == `DRT_IDX_SECOND_LOW) begin
      rd_data = {24'h00_0000, st_r.second_low};
    end else if (rd_idx == `DRT_IDX_CTRL) begin
      rd_data = {24'h00_0000, st_r.ctrl & `DRT_CTRL_WR_MASK};  // RULE1
    end else if (rd_idx == `DRT_IDX_FLAGS) begin
      rd_data = {30'h0000_0000, st_r.flags};
    end else if (rd_idx == `DRT_IDX_MASK) begin
      rd_data = {30'h0000_0000, st_r.mask};
    end else if (rd_idx == `DRT_IDX_DIR) begin
      rd_data = {30'h0000_0000, st_r.dir};
    end else if (rd_idx == `DRT_IDX_DOUT) begin
      rd_data = {30'h0000_0000, st_r.dout};
    end else if (rd_idx == `DRT_IDX_PINS) begin
      rd_data = {30'h0000_0000, st_r.sync2};
    end
  end

  // ==========================================================
  // register file, flags and pins
  always_comb begin
    st_nxt = st_r;
    wb     = wr_data[7:0];
    if (wr_en) begin
      if (wr_idx == `DRT_IDX_FIRST_PRE) begin
        st_nxt.first_pre = wb;  // RULE12
      end else if (wr_idx == `DRT_IDX_SECOND_PRE) begin
        st_nxt.second_pre = wb;  // RULE12
      end else if (wr_idx == `DRT_IDX_FIRST_LOW) begin
        st_nxt.first_low = wb;  // RULE13
      end else if (wr_idx == `DRT_IDX_SECOND_LOW) begin
        st_nxt.second_low = wb;  // RULE13
      end else if (wr_idx == `DRT_IDX_CTRL) begin
        st_nxt.ctrl = wb & `DRT_CTRL_WR_MASK;  // RULE1
      end else if (wr_idx == `DRT_IDX_FLAGS) begin
        st_nxt.flags = st_r.flags & ~wb[1:0];  // RULE9
      end else if (wr_idx == `DRT_IDX_MASK) begin
        st_nxt.mask = wb[1:0];
      end else if (wr_idx == `DRT_IDX_DIR) begin
        st_nxt.dir = wb[1:0];
      end else if (wr_idx == `DRT_IDX_DOUT) begin
        st_nxt.dout = wb[1:0];
      end
    end
    // an event in the clearing cycle wins over the clear
    st_nxt.flags  = st_nxt.flags | irq_ev;  // RULE8 RULE9
    st_nxt.irq    = |(st_nxt.flags & st_nxt.mask);
    // pin inputs are asynchronous
    st_nxt.sync1  = PWM_PIN_I;
    st_nxt.sync2  = st_r.sync1;
    // override follows the mode bit alone, stopped or running
    st_nxt.pin_oe = st_r.dir | mode_v;  // RULE4 RULE16
    st_nxt.pin_o  = (mode_v & pwm_lvl) | (~mode_v & st_r.dout);  // RULE4
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_r <= '{ctrl: `DRT_RST_BYTE, first_pre: `DRT_RST_BYTE,
                second_pre: `DRT_RST_BYTE, first_low: `DRT_RST_BYTE,
                second_low: `DRT_RST_BYTE, flags: `DRT_RST_PAIR,
                mask: `DRT_RST_PAIR, dir: `DRT_RST_PAIR,
                dout: `DRT_RST_PAIR, sync1: `DRT_RST_PAIR,
                sync2: `DRT_RST_PAIR, pin_o: `DRT_RST_PAIR,
                pin_oe: `DRT_RST_PAIR, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign IRQ        = st_r.irq;
  assign PWM_PIN_O  = st_r.pin_o;
  assign PWM_PIN_OE = st_r.pin_oe;

endmodule

// ---- bench/drt_top_sva.sv ----
// concurrent checks on the ports of the dual reload timer top
`timescale 1ns/1ps
`include "drt_regs.svh"
module drt_top_sva
  import drt_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              CLK_SYS,
  input wire logic              RST_B,
  input wire logic              HSEL,
  input wire logic [ADDR_W-1:0] HADDR,
  input wire logic [1:0]        HTRANS,
  input wire logic              HWRITE,
  input wire logic [2:0]        HSIZE,
  input wire logic [31:0]       HWDATA,
  input wire logic [31:0]       HRDATA,
  input wire logic              HREADYOUT,
  input wire logic              HRESP,
  input wire logic              IRQ,
  input wire logic [1:0]        PWM_PIN_O,
  input wire logic [1:0]        PWM_PIN_OE,
  input wire logic [1:0]        PWM_PIN_I
);
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // ==========================================================
  // data phase tracking
  logic       take;
  logic       wdp;
  logic       rdone;
  logic       wfm;
  logic       wr_r;
  logic       rd_r;
  logic [9:0] idx_r;
  assign take  = HSEL & HTRANS[1] & HREADYOUT;
  assign wdp   = wr_r & HREADYOUT;
  assign rdone = rd_r & HREADYOUT;
  assign wfm   = wdp & (idx_r == `DRT_IDX_FLAGS || idx_r == `DRT_IDX_MASK);
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      idx_r <= 10'h000;
    end else if (HREADYOUT) begin
      wr_r  <= take & HWRITE & (HSIZE == `DRT_HSIZE_WORD);
      rd_r  <= take & ~HWRITE;
      idx_r <= 10'(HADDR >> 2);
    end
  end
  // ==========================================================
  // properties
  sequence s_rd_taken;
    take && !HWRITE;
  endsequence
  sequence s_one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  AST_READ_WAIT: assert property (s_rd_taken |=> s_one_wait)
    else $error("read data phase wait state wrong");
  AST_WRITE_NOWAIT: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write data phase not zero wait");
  AST_HRESP_OKAY: assert property (HRESP == 1'b0)
    else $error("error response seen");
  AST_CTRL_RESERVED: assert property (rdone && idx_r == `DRT_IDX_CTRL |-> HRDATA[7:4] == 4'h0)
    else $error("control reserved bits not zero");
  AST_UNMAPPED_ZERO: assert property (rdone && !(idx_r inside {[10'h0aa:10'h0ad],
      [10'h0c0:10'h0c5]}) |-> HRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_FIRST_OE: assert property (wdp && idx_r == `DRT_IDX_CTRL && HWDATA[0]
      |-> ##[1:2] PWM_PIN_OE[0])
    else $error("first pin not forced to output");
  AST_SECOND_OE: assert property (wdp && idx_r == `DRT_IDX_CTRL && HWDATA[2]
      |-> ##[1:2] PWM_PIN_OE[1])
    else $error("second pin not forced to output");
  AST_IRQ_STICKY: assert property (IRQ && !wfm && !$past(wfm) |=> IRQ)
    else $error("interrupt dropped without software clear");
  AST_RESET_QUIET: assert property ($rose(RST_B) |-> !IRQ && PWM_PIN_OE == 2'b00 && HREADYOUT)
    else $error("outputs not quiet after reset");
endmodule

bind drt_top drt_top_sva #(.ADDR_W(ADDR_W)) u_sva (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
  .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ),
  .PWM_PIN_O(PWM_PIN_O), .PWM_PIN_OE(PWM_PIN_OE), .PWM_PIN_I(PWM_PIN_I));

// ---- bench/testbench.sv ----
// self-checking bench for the dual reload timer block
`timescale 1ns/1ps
`include "drt_regs.svh"
module testbench;
  import drt_pkg::*;
  logic        CLK_SYS = 1'b0;
  logic        RST_B = 1'b0;
  logic        HSEL = 1'b0;
  logic [11:0] HADDR = 12'h000;
  logic [1:0]  HTRANS = 2'b00;
  logic        HWRITE = 1'b0;
  logic [2:0]  HSIZE = 3'b010;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        IRQ;
  logic [1:0]  PWM_PIN_O;
  logic [1:0]  PWM_PIN_OE;
  logic [1:0]  PWM_PIN_I = 2'b10;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  int          t0;
  int          hi;
  logic [31:0] q;
  always #4 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) cyc <= cyc + 1;
  drt_top dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .PWM_PIN_O(PWM_PIN_O),
    .PWM_PIN_OE(PWM_PIN_OE), .PWM_PIN_I(PWM_PIN_I));
  // ==========================================================
  // bus and compare tasks
  task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge CLK_SYS);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {i, 2'b00};
    HWRITE <= w;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [9:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic waitirq();
    do @(posedge CLK_SYS); while (IRQ !== 1'b1);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    conclude();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk(10'h0aa + 10'(i), 32'h0000_0000);
    for (int i = 0; i < 3; i++) rdchk(10'h0c0 + 10'(i), 32'h0000_0000);
    xfer(1'b1, 10'h0ff, 32'h0000_00ff);
    rdchk(10'h0ff, 32'h0000_0000);
    rdchk(`DRT_IDX_PINS, 32'h0000_0002);
    // pin levels reach the register only through the two-flop synchroniser
    PWM_PIN_I <= 2'b01;
    repeat (3) @(posedge CLK_SYS);
    rdchk(`DRT_IDX_PINS, 32'h0000_0001);
    xfer(1'b1, `DRT_IDX_CTRL, 32'h0000_00ff);
    rdchk(`DRT_IDX_CTRL, 32'h0000_000f);
    xfer(1'b1, `DRT_IDX_CTRL, 32'h0000_0004);
    // enable is registered from the control bits, one edge after the write lands
    repeat (2) @(posedge CLK_SYS);
    chk(PWM_PIN_OE, 2'b10);
    // pwm duty and period, pin counted over one full period
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, `DRT_IDX_CTRL, 32'h0000_0004);
      xfer(1'b1, `DRT_IDX_SECOND_PRE, p);
      xfer(1'b1, `DRT_IDX_SECOND_LOW, 32'h0000_0064);
      xfer(1'b1, `DRT_IDX_CTRL, 32'h0000_000c);
      repeat (20) @(posedge CLK_SYS);
      hi = 0;
      repeat (255 * (p + 1)) begin
        @(posedge CLK_SYS);
        hi += PWM_PIN_O[1];
      end
      chk(hi, 100 * (p + 1));
    end
    rdchk(`DRT_IDX_FLAGS, 32'h0000_0000);
    xfer(1'b1, `DRT_IDX_CTRL, 32'h0000_0000);
    // timer mode on each channel, reload one gives 510 clocks
    for (int ch = 0; ch < 2; ch++) begin
      xfer(1'b1, `DRT_IDX_MASK, 32'h0000_0003);
      xfer(1'b1, `DRT_IDX_FIRST_PRE + 10'(ch), 32'h0000_0000);
      xfer(1'b1, `DRT_IDX_FIRST_LOW + 10'(ch), 32'h0000_0001);
      xfer(1'b1, `DRT_IDX_CTRL, ch ? 32'h0000_0008 : 32'h0000_0002);
      t0 = cyc;
      waitirq();
      chk((cyc - t0 >= 505) && (cyc - t0 <= 516), 1);
      t0 = cyc;
      repeat (30) @(posedge CLK_SYS);
      rdchk(`DRT_IDX_FLAGS, 32'h1 << ch);
      xfer(1'b1, `DRT_IDX_FLAGS, 32'h0000_0003);
      rdchk(`DRT_IDX_FLAGS, 32'h0000_0000);
      waitirq();
      chk(cyc - t0, 510);
      xfer(1'b1, `DRT_IDX_MASK, 32'h0000_0000);
      repeat (2) @(posedge CLK_SYS);
      chk(IRQ, 1'b0);
      xfer(1'b1, `DRT_IDX_CTRL, 32'h0000_0000);
      xfer(1'b1, `DRT_IDX_FLAGS, 32'h0000_0003);
      xfer(1'b1, `DRT_IDX_MASK, 32'h0000_0003);
      repeat (600) @(posedge CLK_SYS);
      chk(IRQ, 1'b0);
    end
    // timer mode: pin follows direction and data registers
    xfer(1'b1, `DRT_IDX_DIR, 32'h0000_0001);
    xfer(1'b1, `DRT_IDX_DOUT, 32'h0000_0001);
    repeat (2) @(posedge CLK_SYS);
    chk(PWM_PIN_OE, 2'b01);
    chk(PWM_PIN_O, 2'b01);
    // pwm mode while stopped: still forced out, driven low
    xfer(1'b1, `DRT_IDX_DIR, 32'h0000_0000);
    xfer(1'b1, `DRT_IDX_CTRL, 32'h0000_0001);
    repeat (2) @(posedge CLK_SYS);
    chk(PWM_PIN_OE, 2'b01);
    chk(PWM_PIN_O, 2'b00);
    conclude();
  end
endmodule
